// ---- rtl/stop_wake_defines.svh ----
// Purpose: Offsets, field positions, reset values and counts of the
//          stop-mode wakeup controller.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef STOP_WAKE_DEFINES_SVH
`define STOP_WAKE_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SW_OFS_WAKE_CTRL   8'h00
`define SW_OFS_KBD_CTRL    8'h04
`define SW_OFS_STATUS      8'h08
`define SW_OFS_MASK        8'h0C
`define SW_OFS_STATE       8'h10
`define SW_OFS_CLK_CTRL1   8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SW_WC_IRQ_EN       0
`define SW_WC_IRQ_RISE     1
`define SW_WC_STOP_GO      4
`define SW_KC_RISE_LSB     8
`define SW_CC_OSC_KEEP     0
`define SW_CC_LOSS_DIS     1
`define SW_EV_IRQ_PIN      0
`define SW_EV_KBD          1
`define SW_EV_CLK_LOSS     2
`define SW_EV_WAKE         3
`define SW_ST_BUS_CLK      3
`define SW_ST_REGULATOR    4
`define SW_ST_CLK_GEN      5
`define SW_ST_CORE_HALT    6
`define SW_ST_IRQ_PIN      7

// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define SW_EV_W            4
`define SW_RST_WAKE_CTRL   2'h0
`define SW_RST_CLK_CTRL1   2'h0
`define SW_RST_EVENTS      4'h0
`define SW_ENTRY_CYC       4'h4
`define SW_MISS_SLOT       4'h2
`define SW_WAKE_CYC        4'h3

`endif

// ---- rtl/stop_wake_pkg.sv ----
// Purpose: Types shared by the stop-mode wakeup controller.
// Assumes: Compiled before the design modules.
// Notes:   Gray codes along run, entry, stopped, partial, waking.
package stop_wake_pkg;

   typedef enum logic [2:0] {
      PM_RUN     = 3'h0,
      PM_ENTRY   = 3'h1,
      PM_STOPPED = 3'h3,
      PM_PARTIAL = 3'h2,
      PM_WAKING  = 3'h6
   } pm_state_t;

endpackage : stop_wake_pkg

// ---- rtl/pin_edge_detect.sv ----
// Purpose: Per-pin toggle and active-edge detection.
// Assumes: Pins are synchronous to clk_i.
// Notes:   Outputs are one-cycle pulses, one cycle after the pin moves.
`timescale 1ns/1ns
`default_nettype none

module pin_edge_detect #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] pin_i,
   input  wire logic [W-1:0] rise_sel_i,
   output logic      [W-1:0] active_o,
   output logic      [W-1:0] toggle_o
);

   logic armed;

   // No edge is reported until the first sample after reset is held
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         armed <= 1'b0;
      end else begin
         armed <= 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_pin
         logic last;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               last        <= 1'b0;
               active_o[g] <= 1'b0;
               toggle_o[g] <= 1'b0;
            end else begin
               last        <= pin_i[g];
               toggle_o[g] <= armed & (pin_i[g] != last);
               active_o[g] <= armed & (pin_i[g] != last) &
                              (pin_i[g] == rise_sel_i[g]);
            end
         end
      end
   endgenerate

endmodule : pin_edge_detect

`default_nettype wire

// ---- rtl/stop_wake_ctrl.sv ----
// Purpose: Stop-mode entry and wakeup control with Wishbone registers.
// Assumes: clk_i is the always-on wake clock; bus_clk_en_o gates the
//          bus clock. Pins are synchronous to clk_i.
// Notes:   Reproduces this silicon's wake behaviour, faults included.
`timescale 1ns/1ns
`default_nettype none

`include "stop_wake_defines.svh"

module stop_wake_ctrl #(
   parameter int KBD_W = 8
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        irq_pin_i,
   input  wire logic [KBD_W-1:0] keyboard_wake_port_i,
   input  wire logic        clk_loss_i,
   output logic             bus_clk_en_o,
   output logic             regulator_on_o,
   output logic             clock_gen_on_o,
   output logic             osc_run_o,
   output logic             loss_detect_en_o,
   output logic             core_halt_o,
   output logic             stop_mode_o,
   output logic             wake_o,
   output logic             irq_o
);
   import stop_wake_pkg::*;

   // ---------------------------------------------------------------
   // Registers and state
   // ---------------------------------------------------------------
   logic                 irq_pin_en;
   logic                 irq_pin_rise;
   logic [KBD_W-1:0]     kbd_en;
   logic [KBD_W-1:0]     kbd_rise;
   logic                 osc_keep_in_stop;
   logic                 clock_loss_detect_disable;
   logic [`SW_EV_W-1:0]  status;
   logic [`SW_EV_W-1:0]  mask;
   pm_state_t            state;
   pm_state_t            next_state;
   logic [3:0]           cnt;
   logic                 stop_go;
   logic [31:0]          wmask;
   logic                 wr;
   logic                 rd_hit;
   logic [31:0]          rd_data;

   logic [KBD_W:0]       pin_vec;
   logic [KBD_W:0]       rise_vec;
   logic [KBD_W:0]       en_vec;
   logic [KBD_W:0]       act;
   logic [KBD_W:0]       tog;
   logic                 irq_act;
   logic                 kbd_act;
   logic                 miss_slot;
   logic                 loss_evt;
   logic [`SW_EV_W-1:0]  ev_set;
   logic [`SW_EV_W-1:0]  next_status;
   logic                 pin_wake;
   logic                 partial_req;
   logic                 flag_partial;
   logic                 entered_run;

   // ---------------------------------------------------------------
   // Pin edge detection
   // ---------------------------------------------------------------
   assign pin_vec  = {keyboard_wake_port_i, irq_pin_i};
   assign rise_vec = {kbd_rise, irq_pin_rise};
   assign en_vec   = {kbd_en, irq_pin_en};

   pin_edge_detect #(
      .W          (KBD_W + 1)
   ) u_edges (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .pin_i      (pin_vec),
      .rise_sel_i (rise_vec),
      .active_o   (act),
      .toggle_o   (tog)
   );

   // An edge landing in the slot two bus clock edges before the bus
   // clock stops is dropped, as this silicon does. Edges outside that
   // single slot are always caught.
   assign miss_slot = (state == PM_ENTRY) && (cnt == `SW_MISS_SLOT);
   assign irq_act   = act[0] & en_vec[0] & ~miss_slot;
   assign kbd_act   = |(act[KBD_W:1] & en_vec[KBD_W:1]) & ~miss_slot;

   // The detector only watches a running oscillator: in the stopped state that is
   // only when the oscillator is kept alive. Its false alarms pass.
   assign loss_evt = clk_loss_i & ~clock_loss_detect_disable &
                     osc_run_o;

   always_comb begin
      ev_set = '0;
      ev_set[`SW_EV_IRQ_PIN] = irq_act;
      ev_set[`SW_EV_KBD]     = kbd_act;
      ev_set[`SW_EV_CLK_LOSS] = loss_evt;
      ev_set[`SW_EV_WAKE]    = entered_run;
   end

   // ---------------------------------------------------------------
   // Wake decision
   // ---------------------------------------------------------------
   // Full wake only from clock loss or from an enabled pin whose interrupt is unmasked and
   // whose flag is (or is being) set.
   assign pin_wake =
      (irq_pin_en & mask[`SW_EV_IRQ_PIN] &
       next_status[`SW_EV_IRQ_PIN]) |
      ((|kbd_en) & mask[`SW_EV_KBD] & next_status[`SW_EV_KBD]);

   // Enabled pin with its interrupt off: any toggle brings up the
   // regulator and clocks but not the core.
   assign partial_req =
      (tog[0] & en_vec[0] & ~mask[`SW_EV_IRQ_PIN]) |
      (|(tog[KBD_W:1] & en_vec[KBD_W:1]) & ~mask[`SW_EV_KBD]);

   assign flag_partial =
      (status[`SW_EV_IRQ_PIN] & irq_pin_en & ~mask[`SW_EV_IRQ_PIN]) |
      (status[`SW_EV_KBD] & (|kbd_en) & ~mask[`SW_EV_KBD]);

   // ---------------------------------------------------------------
   // Power mode sequencer
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         PM_RUN: begin
            if (stop_go) begin
               next_state = PM_ENTRY;
            end
         end
         PM_ENTRY: begin
            if (cnt == 4'h1) begin
               if (flag_partial) begin
                  next_state = PM_PARTIAL;
               end else begin
                  next_state = PM_STOPPED;
               end
            end
         end
         PM_STOPPED: begin
            if (pin_wake || loss_evt) begin
               next_state = PM_WAKING;
            end else if (partial_req) begin
               next_state = PM_PARTIAL;
            end
         end
         PM_PARTIAL: begin
            if (pin_wake || loss_evt) begin
               next_state = PM_WAKING;
            end
         end
         PM_WAKING: begin
            if (cnt == 4'h1) begin
               next_state = PM_RUN;
            end
         end
         default: begin
            next_state = PM_RUN;
         end
      endcase
   end

   assign entered_run = (state == PM_WAKING) && (next_state == PM_RUN);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= PM_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Entry and wake delays share one down counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 4'h0;
      end else if (state == PM_RUN && next_state == PM_ENTRY) begin
         cnt <= `SW_ENTRY_CYC;
      end else if (state != PM_WAKING && next_state == PM_WAKING) begin
         cnt <= `SW_WAKE_CYC;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // Power and clock outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_clk_en_o   <= 1'b1;
         regulator_on_o <= 1'b1;
         clock_gen_on_o <= 1'b1;
         osc_run_o      <= 1'b1;
         core_halt_o    <= 1'b0;
         stop_mode_o    <= 1'b0;
         wake_o         <= 1'b0;
      end else begin
         bus_clk_en_o   <= (next_state == PM_RUN) ||
                           (next_state == PM_ENTRY);
         regulator_on_o <= (next_state != PM_STOPPED);
         clock_gen_on_o <= (next_state != PM_STOPPED);
         osc_run_o      <= (next_state != PM_STOPPED) ||
                           osc_keep_in_stop;
         core_halt_o    <= (next_state != PM_RUN) &&
                           (next_state != PM_ENTRY);
         stop_mode_o    <= (next_state != PM_RUN) &&
                           (next_state != PM_ENTRY);
         wake_o         <= entered_run;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loss_detect_en_o <= 1'b0;
      end else begin
         loss_detect_en_o <= ~clock_loss_detect_disable;
      end
   end

   // ---------------------------------------------------------------
   // Wishbone slave
   // ---------------------------------------------------------------
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wr    = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      end
   end

   // Stop request is a one-cycle command; reads back as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_go <= 1'b0;
      end else begin
         stop_go <= wr && (wb_adr_i == `SW_OFS_WAKE_CTRL) &&
                    wb_sel_i[0] && wb_dat_i[`SW_WC_STOP_GO];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {irq_pin_rise, irq_pin_en} <= `SW_RST_WAKE_CTRL;
      end else if (wr && wb_adr_i == `SW_OFS_WAKE_CTRL && wb_sel_i[0]) begin
         irq_pin_en   <= wb_dat_i[`SW_WC_IRQ_EN];
         irq_pin_rise <= wb_dat_i[`SW_WC_IRQ_RISE];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         kbd_en   <= '0;
         kbd_rise <= '0;
      end else if (wr && wb_adr_i == `SW_OFS_KBD_CTRL) begin
         if (wb_sel_i[0]) begin
            kbd_en <= wb_dat_i[KBD_W-1:0];
         end
         if (wb_sel_i[1]) begin
            kbd_rise <= wb_dat_i[`SW_KC_RISE_LSB +: KBD_W];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {clock_loss_detect_disable, osc_keep_in_stop} <= `SW_RST_CLK_CTRL1;
      end else if (wr && wb_adr_i == `SW_OFS_CLK_CTRL1 && wb_sel_i[0]) begin
         osc_keep_in_stop          <= wb_dat_i[`SW_CC_OSC_KEEP];
         clock_loss_detect_disable <= wb_dat_i[`SW_CC_LOSS_DIS];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask <= `SW_RST_EVENTS;
      end else if (wr && wb_adr_i == `SW_OFS_MASK && wb_sel_i[0]) begin
         mask <= wb_dat_i[`SW_EV_W-1:0];
      end
   end

   // Write one to clear; a new event in the same cycle wins
   always_comb begin
      next_status = status;
      if (wr && wb_adr_i == `SW_OFS_STATUS && wb_sel_i[0]) begin
         next_status = status & ~wb_dat_i[`SW_EV_W-1:0];
      end
      next_status = next_status | ev_set;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= `SW_RST_EVENTS;
      end else begin
         status <= next_status;
      end
   end

   // No chip interrupt while only partly awake
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (|(next_status & mask)) &&
                  (next_state != PM_PARTIAL);
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (wb_adr_i)
         `SW_OFS_WAKE_CTRL: begin
            rd_data[`SW_WC_IRQ_EN]   = irq_pin_en;
            rd_data[`SW_WC_IRQ_RISE] = irq_pin_rise;
         end
         `SW_OFS_KBD_CTRL: begin
            rd_data[KBD_W-1:0]                 = kbd_en;
            rd_data[`SW_KC_RISE_LSB +: KBD_W] = kbd_rise;
         end
         `SW_OFS_STATUS: begin
            rd_data[`SW_EV_W-1:0] = status;
         end
         `SW_OFS_MASK: begin
            rd_data[`SW_EV_W-1:0] = mask;
         end
         `SW_OFS_STATE: begin
            rd_data[2:0]              = state;
            rd_data[`SW_ST_BUS_CLK]   = bus_clk_en_o;
            rd_data[`SW_ST_REGULATOR] = regulator_on_o;
            rd_data[`SW_ST_CLK_GEN]   = clock_gen_on_o;
            rd_data[`SW_ST_CORE_HALT] = core_halt_o;
            rd_data[`SW_ST_IRQ_PIN]   = irq_pin_i;
         end
         `SW_OFS_CLK_CTRL1: begin
            rd_data[`SW_CC_OSC_KEEP] = osc_keep_in_stop;
            rd_data[`SW_CC_LOSS_DIS] = clock_loss_detect_disable;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // Unmapped reads return zero and still acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
         wb_dat_o <= rd_hit ? (rd_data & wmask) : 32'h0000_0000;
      end
   end

endmodule : stop_wake_ctrl

`default_nettype wire

// ---- tb/stop_wake_properties.sv ----
// Purpose: Port-level checks of the stop wakeup controller.
// Assumes: Bound into stop_wake_ctrl; one clock domain.
// Notes:   Sees the top module ports only.
`timescale 1ns/1ns
`default_nettype none

module stop_wake_properties (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic clk_loss_i,
   input wire logic bus_clk_en_o,
   input wire logic regulator_on_o,
   input wire logic clock_gen_on_o,
   input wire logic osc_run_o,
   input wire logic loss_detect_en_o,
   input wire logic core_halt_o,
   input wire logic stop_mode_o,
   input wire logic wake_o,
   input wire logic irq_o
);
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_next_edge: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered on the next edge");
   a_reset_state: assert property ($fell(rst_i) |-> bus_clk_en_o
      && regulator_on_o && osc_run_o && !stop_mode_o && !irq_o)
      else $error("outputs off their reset values");
   a_bus_clk_gate: assert property (!stop_mode_o |-> bus_clk_en_o
      && regulator_on_o && clock_gen_on_o && osc_run_o && !core_halt_o)
      else $error("run mode with a clock or supply off");
   a_core_halt: assert property (core_halt_o == stop_mode_o)
      else $error("core halt disagrees with stop state");
   a_partial_quiet: assert property
      ((stop_mode_o && regulator_on_o)[*6] |->
       clock_gen_on_o && core_halt_o && !irq_o)
      else $error("partial wakeup raised an interrupt");
   a_wake_pulse: assert property (wake_o |-> $fell(stop_mode_o))
      else $error("wake pulse without leaving stop");
   a_loss_wakes: assert property (stop_mode_o && clk_loss_i
      && loss_detect_en_o && osc_run_o |-> ##[0:8] wake_o)
      else $error("clock loss did not wake the device");

   c_partial: cover property ((stop_mode_o && regulator_on_o)[*6]);
   c_wake: cover property (wake_o);
   c_loss: cover property (stop_mode_o && clk_loss_i && osc_run_o);
endmodule : stop_wake_properties

bind stop_wake_ctrl stop_wake_properties u_props (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .clk_loss_i, .bus_clk_en_o,
   .regulator_on_o, .clock_gen_on_o, .osc_run_o, .loss_detect_en_o,
   .core_halt_o, .stop_mode_o, .wake_o, .irq_o);

`default_nettype wire

// ---- tb/pin_source.sv ----
// Purpose: Pin and clock-monitor sources facing the wakeup controller.
// Assumes: Levels asked for by the bench, registered on clk_i.
// Notes:   slow_i adds one cycle, like a source further away.
`timescale 1ns/1ns
`default_nettype none

module pin_source (
   input  wire logic       clk_i,
   input  wire logic       slow_i,
   input  wire logic       irq_lvl_i,
   input  wire logic [7:0] kbd_lvl_i,
   input  wire logic       loss_i,
   output logic            irq_pin_o,
   output logic      [7:0] kbd_o,
   output logic            clk_loss_o
);
   // ---------------------------------------------------------------
   // Sources
   // ---------------------------------------------------------------
   logic [9:0] hold;

   initial begin
      hold = 10'h001;
      {clk_loss_o, kbd_o, irq_pin_o} = 10'h001;
   end

   always @(posedge clk_i) begin
      hold <= {loss_i, kbd_lvl_i, irq_lvl_i};
      {clk_loss_o, kbd_o, irq_pin_o} <= slow_i ? hold :
         {loss_i, kbd_lvl_i, irq_lvl_i};
   end
endmodule : pin_source

`default_nettype wire

// ---- tb/test_stop_wake_ctrl.sv ----
// Purpose: Self-checking bench of the stop wakeup controller.
// Assumes: Pins come from pin_source, registers over Wishbone.
// Notes:   An entry sweep looks for the single lost edge slot.
`timescale 1ns/1ns
`default_nettype none
`include "stop_wake_defines.svh"

module test_stop_wake_ctrl;
   import stop_wake_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus and checks
   // ---------------------------------------------------------------
   localparam logic [7:0] WC = `SW_OFS_WAKE_CTRL;
   localparam logic [7:0] KC = `SW_OFS_KBD_CTRL;
   localparam logic [7:0] ST = `SW_OFS_STATUS;
   localparam logic [7:0] MK = `SW_OFS_MASK;
   localparam logic [7:0] CC = `SW_OFS_CLK_CTRL1;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0]  adr = 8'h00, kbd_lvl = 8'h00, kbd;
   logic [31:0] dat = 32'h0, q, rdat;
   logic [3:0]  sel = 4'hF;
   logic        irq_lvl = 1, loss = 0, slow = 0, irq_pin, clk_loss;
   logic        ack, bus_en, reg_on, cg_on, osc_run, lde, halt, stop;
   logic        wake, irq;
   int          n_errors = 0, cmp_count = 0, seed = 9, k, off, misses;

   initial forever #2 clk_i = ~clk_i;

   pin_source src (.clk_i, .slow_i(slow), .irq_lvl_i(irq_lvl),
      .kbd_lvl_i(kbd_lvl), .loss_i(loss), .irq_pin_o(irq_pin),
      .kbd_o(kbd), .clk_loss_o(clk_loss));
   stop_wake_ctrl dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_pin_i(irq_pin),
      .keyboard_wake_port_i(kbd), .clk_loss_i(clk_loss),
      .bus_clk_en_o(bus_en), .regulator_on_o(reg_on),
      .clock_gen_on_o(cg_on), .osc_run_o(osc_run),
      .loss_detect_en_o(lde), .core_halt_o(halt), .stop_mode_o(stop),
      .wake_o(wake), .irq_o(irq));

   task summarize;
      if (n_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task bail;
      n_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      summarize();
   endtask : bail

   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20)
         bail();
   endtask : wb

   task rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd

   // Waits for stop_mode (s = 0) or the wake pulse (s = 1)
   task wait_on(input int s, input int lim);
      int n;
      n = 0;
      while ((s ? wake : stop) !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= lim)
         bail();
   endtask : wait_on

   task edge_k;
      kbd_lvl[k] <= 1'b0;
      repeat (3) @(posedge clk_i);
      kbd_lvl[k] <= 1'b1;
   endtask : edge_k

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `SW_OFS_STATE, 32'h0);
      chk(q & 32'h7F, 32'h38);
      rd(CC, 32'h0);
      rd(8'h20, 32'h0);
      wb(1'b1, MK, 32'hF);
      rd(MK, 32'hF);
      rd(ST, 32'h0);
      wb(1'b1, MK, 32'h0);
      wb(1'b1, WC, 32'h1);
      irq_lvl <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(ST, 32'h1);
      chk(32'(irq), 32'h0);
      wb(1'b1, MK, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(32'(irq), 32'h1);
      wb(1'b1, MK, 32'h0);
      repeat (2) @(posedge clk_i);
      chk(32'(irq), 32'h0);
      wb(1'b1, MK, 32'h1);
      wb(1'b1, ST, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(32'(irq), 32'h0);
      rd(ST, 32'h0);
      irq_lvl <= 1'b1;
      wb(1'b1, WC, 32'h0);
      // Edge swept across the entry countdown
      k = $random(seed) & 7;
      wb(1'b1, KC, 32'h101 << k);
      wb(1'b1, MK, 32'h2);
      misses = 0;
      for (off = 0; off < 8; off++) begin
         // The lost slot is only reachable with the short source path
         slow <= (off == 0) ? 1'b0 : 1'($random(seed));
         wb(1'b1, ST, 32'hF);
         wb(1'b1, WC, 32'h10);
         repeat (off) @(posedge clk_i);
         kbd_lvl[k] <= 1'b1;
         repeat (14) @(posedge clk_i);
         wb(1'b0, ST, 32'h0);
         chk(32'(q[1]), 32'(off != 0));
         if (q[1] !== 1'b1) begin
            misses++;
            chk(32'({stop, irq}), 32'h2);
         end
         if (stop === 1'b1) begin
            edge_k();
            wait_on(1, 40);
         end
         kbd_lvl[k] <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
      chk(32'(misses), 32'h1);
      // Partial wakeup, masked pin
      wb(1'b1, MK, 32'h0);
      wb(1'b1, CC, 32'h1);
      wb(1'b1, ST, 32'hF);
      wb(1'b1, WC, 32'h10);
      wait_on(0, 20);
      repeat (2) @(posedge clk_i);
      chk(32'({bus_en, reg_on, cg_on, osc_run}), 32'h1);
      kbd_lvl[k] <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk(32'({reg_on, cg_on, halt, stop, irq}), 32'h1E);
      loss <= 1'b1;
      wait_on(1, 20);
      loss <= 1'b0;
      rd(ST, 32'hE);
      wb(1'b1, ST, 32'hC);
      wb(1'b1, WC, 32'h10);
      wait_on(0, 20);
      repeat (3) @(posedge clk_i);
      chk(32'({reg_on, halt, irq}), 32'h6);
      loss <= 1'b1;
      wait_on(1, 20);
      loss <= 1'b0;
      // Unused pins switched off before stop
      wb(1'b1, KC, 32'h0);
      wb(1'b1, ST, 32'hF);
      wb(1'b1, WC, 32'h10);
      wait_on(0, 20);
      edge_k();
      repeat (8) @(posedge clk_i);
      chk(32'({reg_on, stop}), 32'h1);
      loss <= 1'b1;
      wait_on(1, 20);
      loss <= 1'b0;
      // Loss detection disabled, pin wakes instead
      wb(1'b1, CC, 32'h3);
      wb(1'b1, ST, 32'hF);
      wb(1'b1, MK, 32'h1);
      wb(1'b1, WC, 32'h11);
      chk(32'(lde), 32'h0);
      wait_on(0, 20);
      loss <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk(32'({stop, reg_on}), 32'h2);
      loss <= 1'b0;
      irq_lvl <= 1'b0;
      wait_on(1, 20);
      repeat (2) @(posedge clk_i);
      rd(ST, 32'h9);
      summarize();
   end
endmodule : test_stop_wake_ctrl

`default_nettype wire
